// ===== rtl/cip_pkg.sv
// shared constants and state types for the card command link
package cip_pkg;

  // ==========================================================
  // command header
  localparam logic [7:0] CLA_VALUE        = 8'h00;
  localparam logic [7:0] INS_INCREASE     = 8'h32;
  localparam logic [7:0] INS_VERIFY       = 8'h20;
  localparam logic [7:0] INS_CHANGE       = 8'h24;
  localparam logic [7:0] AM_TAG_INCREASE  = 8'h84;
  localparam logic [7:0] P_ZERO           = 8'h00;
  localparam logic [2:0] SFI_FLAG         = 3'h4;
  localparam logic [1:0] QUAL_ZERO        = 2'h0;
  localparam logic [4:0] KEY_REF_NONE     = 5'h00;
  localparam logic [7:0] LC_EMPTY         = 8'h00;
  localparam logic [7:0] LC_INC_MAX       = 8'h7F;
  localparam logic [7:0] LC_PIN           = 8'h08;
  localparam logic [7:0] LC_CHANGE        = 8'h10;
  localparam logic [2:0] HDR_CLA          = 3'h0;
  localparam logic [2:0] HDR_INS          = 3'h1;
  localparam logic [2:0] HDR_P1           = 3'h2;
  localparam logic [2:0] HDR_P2           = 3'h3;
  localparam logic [2:0] HDR_LC           = 3'h4;
  localparam int         BUF_BYTES        = 16;
  localparam int         PIN_BITS         = 64;
  localparam logic [1:0] RETRY_INIT       = 2'h3;
  localparam logic [1:0] RETRY_NONE       = 2'h0;

  // ==========================================================
  // status words
  localparam logic [15:0] SW_OK           = 16'h9000;
  localparam logic [15:0] SW_RETRY_BASE   = 16'h63C0;
  localparam logic [15:0] SW_BLOCKED      = 16'h6983;
  localparam logic [15:0] SW_DISABLED     = 16'h6984;
  localparam logic [15:0] SW_DENIED       = 16'h6982;
  localparam logic [15:0] SW_WRONG_LEN    = 16'h6700;
  localparam logic [15:0] SW_WRONG_P1P2   = 16'h6B00;
  localparam logic [15:0] SW_NO_FILE      = 16'h6A82;
  localparam logic [15:0] SW_NO_REF       = 16'h6A88;
  localparam logic [15:0] SW_OVERFLOW     = 16'h6A84;
  localparam logic [15:0] SW_BAD_INS      = 16'h6D00;

  // ==========================================================
  // state types
  typedef enum logic [4:0] {
    CS_HDR  = 5'b00001,
    CS_DATA = 5'b00010,
    CS_EXEC = 5'b00100,
    CS_RESP = 5'b01000,
    CS_SW   = 5'b10000
  } cip_card_state_t;

  typedef enum logic [3:0] {
    TS_IDLE = 4'b0001,
    TS_HDR  = 4'b0010,
    TS_DATA = 4'b0100,
    TS_RESP = 4'b1000
  } cip_term_state_t;

endpackage

// ===== rtl/cip_link_if.sv
// byte link between terminal and card
`timescale 1ns/1ps
`default_nettype none
interface cip_link_if;
  logic       t2c_valid;
  logic       t2c_ready;
  logic [7:0] t2c_data;
  logic       c2t_valid;
  logic       c2t_ready;
  logic [7:0] c2t_data;
  logic       c2t_last;

  modport card (
    input  t2c_valid, t2c_data, c2t_ready,
    output t2c_ready, c2t_valid, c2t_data, c2t_last
  );
  modport term (
    output t2c_valid, t2c_data, c2t_ready,
    input  t2c_ready, c2t_valid, c2t_data, c2t_last
  );
endinterface
`default_nettype wire

// ===== rtl/cip_card.sv
// card end: increase, verify and change commands
`timescale 1ns/1ps
`default_nettype none
module cip_card #(
  parameter int          NREC        = 4,
  parameter int          RECLEN      = 4,
  parameter int          NPIN        = 4,
  parameter logic [4:0]  FILE_SFI    = 5'h01,
  parameter logic [63:0] PIN_DEFAULT = 64'h3132_3334_FFFF_FFFF
) (
  input  wire logic                    mclk_in,
  input  wire logic                    rst_n_in,
  cip_link_if.card                     link,
  input  wire logic                    nv_init_in,
  input  wire logic [NPIN-1:0]         pin_disabled_in,
  input  wire logic [7:0]              am_tag_in,
  input  wire logic [7:0]              am_ins_in,
  input  wire logic                    inc_cond_met_in,
  input  wire logic                    inc_pin_protected_in,
  input  wire logic [$clog2(NPIN)-1:0] inc_pin_idx_in,
  output logic      [NPIN-1:0]         pin_verified_out,
  output logic      [NPIN-1:0]         pin_blocked_out,
  output logic      [$clog2(NREC)-1:0] rec_ptr_out
);
  import cip_pkg::*;

  localparam int RW = RECLEN * 8;
  localparam int BW = BUF_BYTES * 8;
  localparam int PW = $clog2(NPIN);
  localparam int QW = $clog2(NREC);

  // ==========================================================
  // response byte picker
  function automatic logic [7:0] rsp_byte(input logic [RW-1:0] rec,
                                          input logic [BW-1:0] val,
                                          input logic [7:0]    lc,
                                          input logic [7:0]    idx);
    int k;
    k = 0;
    if (int'(idx) < RECLEN) begin
      k = RECLEN - 1 - int'(idx);
      rsp_byte = rec[k*8 +: 8];
    end else begin
      k = int'(lc) - 1 - (int'(idx) - RECLEN);
      if (k < 0 || k >= BUF_BYTES) k = 0;
      rsp_byte = val[k*8 +: 8];
    end
  endfunction

  // ==========================================================
  // state
  cip_card_state_t state_reg, state_next;
  logic [2:0]      hdr_cnt_reg, hdr_cnt_next;
  logic [7:0]      ins_reg, ins_next, p1_reg, p1_next;
  logic [7:0]      p2_reg, p2_next, lc_reg, lc_next;
  logic [7:0]      dat_cnt_reg, dat_cnt_next;
  logic [7:0]      rsp_cnt_reg, rsp_cnt_next, rsp_len_reg, rsp_len_next;
  logic [BW-1:0]   buf_reg, buf_next;
  logic [RW-1:0]   rsp_rec_reg, rsp_rec_next;
  logic [15:0]     sw_reg, sw_next;
  logic            sw_idx_reg, sw_idx_next;
  logic [NPIN-1:0] verified_reg, verified_next;
  // nonvolatile image, untouched by rst_n_in
  logic [RW-1:0]       rec_reg [NREC];
  logic [RW-1:0]       rec_next [NREC];
  logic [QW-1:0]       ptr_reg, ptr_next;
  logic [PIN_BITS-1:0] pin_reg [NPIN];
  logic [PIN_BITS-1:0] pin_next [NPIN];
  logic [1:0]          tries_reg [NPIN];
  logic [1:0]          tries_next [NPIN];
  logic [NPIN-1:0]     blocked_reg, blocked_next;

  logic          hs_in, hs_out, ref_ok;
  logic [PW-1:0] pidx;
  logic [RW:0]   sum;
  logic [1:0]    left;

  assign hs_in  = link.t2c_valid && link.t2c_ready;
  assign hs_out = link.c2t_valid && link.c2t_ready;
  assign link.t2c_ready = (state_reg == CS_HDR) || (state_reg == CS_DATA);
  assign link.c2t_valid = (state_reg == CS_RESP) || (state_reg == CS_SW);
  assign link.c2t_last  = (state_reg == CS_SW) && sw_idx_reg;
  assign link.c2t_data  = (state_reg == CS_RESP) ?
                          rsp_byte(rsp_rec_reg, buf_reg, lc_reg, rsp_cnt_reg) :
                          (sw_idx_reg ? sw_reg[7:0] : sw_reg[15:8]);
  assign pin_verified_out = verified_reg;
  assign pin_blocked_out  = blocked_reg;
  assign rec_ptr_out      = ptr_reg;

  assign pidx   = PW'(p2_reg[4:0] - 5'h01);
  assign ref_ok = (p2_reg[4:0] != KEY_REF_NONE) &&
                  (int'(p2_reg[4:0]) <= NPIN);
  assign sum    = {1'b0, rec_reg[ptr_reg]} + {1'b0, buf_reg[RW-1:0]};
  assign left   = tries_reg[pidx] - 2'h1;

  // ==========================================================
  // next state
  always_comb begin
    state_next    = state_reg;
    hdr_cnt_next  = hdr_cnt_reg;
    ins_next      = ins_reg;
    p1_next       = p1_reg;
    p2_next       = p2_reg;
    lc_next       = lc_reg;
    dat_cnt_next  = dat_cnt_reg;
    rsp_cnt_next  = rsp_cnt_reg;
    rsp_len_next  = rsp_len_reg;
    buf_next      = buf_reg;
    rsp_rec_next  = rsp_rec_reg;
    sw_next       = sw_reg;
    sw_idx_next   = sw_idx_reg;
    verified_next = verified_reg;
    rec_next      = rec_reg;
    ptr_next      = ptr_reg;
    pin_next      = pin_reg;
    tries_next    = tries_reg;
    blocked_next  = blocked_reg;
    case (state_reg)
      CS_HDR: begin
        if (hs_in) begin
          hdr_cnt_next = hdr_cnt_reg + 3'h1;
          case (hdr_cnt_reg)
            HDR_CLA: buf_next = '0;
            HDR_INS: ins_next = link.t2c_data;
            HDR_P1:  p1_next  = link.t2c_data;
            HDR_P2:  p2_next  = link.t2c_data;
            default: begin
              lc_next      = link.t2c_data;
              hdr_cnt_next = HDR_CLA;
              dat_cnt_next = '0;
              state_next   = (link.t2c_data == LC_EMPTY) ? CS_EXEC : CS_DATA;
            end
          endcase
        end
      end
      CS_DATA: begin
        if (hs_in) begin
          buf_next     = {buf_reg[BW-9:0], link.t2c_data};
          dat_cnt_next = dat_cnt_reg + 8'h01;
          if (dat_cnt_next == lc_reg) state_next = CS_EXEC;
        end
      end
      CS_EXEC: begin
        rsp_len_next = '0;
        rsp_cnt_next = '0;
        sw_idx_next  = 1'b0;
        sw_next      = SW_OK;
        case (ins_reg)
          INS_INCREASE: begin
            if (p2_reg != P_ZERO ||
                (p1_reg != P_ZERO && p1_reg[7:5] != SFI_FLAG))
              sw_next = SW_WRONG_P1P2;
            else if (p1_reg != P_ZERO &&
                     (p1_reg[4:0] != FILE_SFI || FILE_SFI == KEY_REF_NONE))
              sw_next = SW_NO_FILE;
            else if (lc_reg == LC_EMPTY || lc_reg > LC_INC_MAX ||
                     int'(lc_reg) > RECLEN)
              sw_next = SW_WRONG_LEN;
            else if (am_tag_in != AM_TAG_INCREASE ||
                     am_ins_in != INS_INCREASE || !inc_cond_met_in)
              sw_next = SW_DENIED;
            else if (inc_pin_protected_in &&
                     !(verified_reg[inc_pin_idx_in] ||
                       pin_disabled_in[inc_pin_idx_in]))
              sw_next = SW_DENIED;
            else if (sum[RW])
              sw_next = SW_OVERFLOW;
            else begin
              ptr_next = (int'(ptr_reg) == NREC - 1) ? '0 :
                         QW'(ptr_reg + 1'b1);
              rec_next[ptr_next] = sum[RW-1:0];
              rsp_rec_next = sum[RW-1:0];
              rsp_len_next = 8'(RECLEN) + lc_reg;
            end
          end
          INS_VERIFY, INS_CHANGE: begin
            if (p1_reg != P_ZERO || p2_reg[6:5] != QUAL_ZERO ||
                p2_reg[4:0] == KEY_REF_NONE)
              sw_next = SW_WRONG_P1P2;
            else if (!ref_ok)
              sw_next = SW_NO_REF;
            else if ((ins_reg == INS_CHANGE && lc_reg != LC_CHANGE) ||
                     (ins_reg == INS_VERIFY && lc_reg != LC_EMPTY &&
                      lc_reg != LC_PIN))
              sw_next = SW_WRONG_LEN;
            else if (lc_reg == LC_EMPTY)
              sw_next = blocked_reg[pidx] ? SW_RETRY_BASE :
                        (SW_RETRY_BASE | 16'(tries_reg[pidx]));
            else if (blocked_reg[pidx])
              sw_next = SW_BLOCKED;
            else if (pin_disabled_in[pidx])
              sw_next = SW_DISABLED;
            else if ((ins_reg == INS_CHANGE ?
                      buf_reg[2*PIN_BITS-1:PIN_BITS] :
                      buf_reg[PIN_BITS-1:0]) == pin_reg[pidx]) begin
              tries_next[pidx]    = RETRY_INIT;
              verified_next[pidx] = 1'b1;
              if (ins_reg == INS_CHANGE)
                pin_next[pidx] = buf_reg[PIN_BITS-1:0];
            end else begin
              tries_next[pidx]    = left;
              verified_next[pidx] = 1'b0;
              sw_next             = SW_RETRY_BASE | 16'(left);
              if (left == RETRY_NONE) blocked_next[pidx] = 1'b1;
            end
          end
          default: sw_next = SW_BAD_INS;
        endcase
        state_next = (rsp_len_next == 8'h00) ? CS_SW : CS_RESP;
      end
      CS_RESP: begin
        if (hs_out) begin
          rsp_cnt_next = rsp_cnt_reg + 8'h01;
          if (rsp_cnt_next == rsp_len_reg) state_next = CS_SW;
        end
      end
      CS_SW: begin
        if (hs_out) begin
          sw_idx_next = 1'b1;
          if (sw_idx_reg) state_next = CS_HDR;
        end
      end
      default: state_next = CS_HDR;
    endcase
    if (nv_init_in) begin
      for (int i = 0; i < NREC; i++) rec_next[i] = '0;
      for (int i = 0; i < NPIN; i++) begin
        pin_next[i]   = PIN_DEFAULT;
        tries_next[i] = RETRY_INIT;
      end
      ptr_next     = '0;
      blocked_next = '0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg    <= CS_HDR;
      hdr_cnt_reg  <= HDR_CLA;
      ins_reg      <= '0;
      p1_reg       <= '0;
      p2_reg       <= '0;
      lc_reg       <= '0;
      dat_cnt_reg  <= '0;
      rsp_cnt_reg  <= '0;
      rsp_len_reg  <= '0;
      buf_reg      <= '0;
      rsp_rec_reg  <= '0;
      sw_reg       <= SW_OK;
      sw_idx_reg   <= 1'b0;
      verified_reg <= '0;
    end else begin
      state_reg    <= state_next;
      hdr_cnt_reg  <= hdr_cnt_next;
      ins_reg      <= ins_next;
      p1_reg       <= p1_next;
      p2_reg       <= p2_next;
      lc_reg       <= lc_next;
      dat_cnt_reg  <= dat_cnt_next;
      rsp_cnt_reg  <= rsp_cnt_next;
      rsp_len_reg  <= rsp_len_next;
      buf_reg      <= buf_next;
      rsp_rec_reg  <= rsp_rec_next;
      sw_reg       <= sw_next;
      sw_idx_reg   <= sw_idx_next;
      verified_reg <= verified_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    rec_reg     <= rec_next;
    ptr_reg     <= ptr_next;
    pin_reg     <= pin_next;
    tries_reg   <= tries_next;
    blocked_reg <= blocked_next;
  end
endmodule
`default_nettype wire

// ===== rtl/cip_term.sv
// terminal end: sends one command, collects reply and status
`timescale 1ns/1ps
`default_nettype none
module cip_term #(
  parameter int RSP_BYTES = 40
) (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  cip_link_if.term                    link,
  input  wire logic                   req_valid_in,
  output logic                        req_ready_out,
  input  wire logic [7:0]             ins_in,
  input  wire logic [7:0]             p1_in,
  input  wire logic [7:0]             p2_in,
  input  wire logic [7:0]             lc_in,
  input  wire logic [127:0]           data_in,
  output logic                        done_out,
  output logic                        refused_out,
  output logic [15:0]                 sw_out,
  output logic [RSP_BYTES*8-1:0]      rsp_data_out,
  output logic [7:0]                  rsp_count_out
);
  import cip_pkg::*;

  localparam int BW = BUF_BYTES * 8;
  localparam int RB = RSP_BYTES * 8;

  // ==========================================================
  // command legality
  function automatic logic legal(input logic [7:0] ins, input logic [7:0] p1,
                                 input logic [7:0] p2, input logic [7:0] lc);
    logic p2_ok;
    p2_ok = (p2[6:5] == QUAL_ZERO) && (p2[4:0] != KEY_REF_NONE);
    case (ins)
      INS_INCREASE: legal = (p1 == P_ZERO || p1[7:5] == SFI_FLAG) &&
                            p2 == P_ZERO && lc != LC_EMPTY &&
                            lc <= LC_INC_MAX;
      INS_VERIFY:   legal = p1 == P_ZERO && p2_ok &&
                            (lc == LC_EMPTY || lc == LC_PIN);
      INS_CHANGE:   legal = p1 == P_ZERO && p2_ok && lc == LC_CHANGE;
      default:      legal = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // state
  cip_term_state_t state_reg, state_next;
  logic [2:0]      hdr_cnt_reg, hdr_cnt_next;
  logic [7:0]      ins_reg, ins_next, p1_reg, p1_next;
  logic [7:0]      p2_reg, p2_next, lc_reg, lc_next;
  logic [7:0]      cnt_reg, cnt_next;
  logic [BW-1:0]   data_reg, data_next;
  logic            done_reg, done_next, refused_reg, refused_next;
  logic [15:0]     sw_reg, sw_next;
  logic [RB-1:0]   rsp_reg, rsp_next;
  logic [7:0]      rcnt_reg, rcnt_next;
  logic [7:0]      hdr_byte;
  int              k;

  always_comb begin
    k = int'(lc_reg) - 1 - int'(cnt_reg);
    if (k < 0 || k >= BUF_BYTES) k = 0;
    case (hdr_cnt_reg)
      HDR_CLA: hdr_byte = CLA_VALUE;
      HDR_INS: hdr_byte = ins_reg;
      HDR_P1:  hdr_byte = p1_reg;
      HDR_P2:  hdr_byte = p2_reg;
      default: hdr_byte = lc_reg;
    endcase
  end

  assign req_ready_out  = (state_reg == TS_IDLE);
  assign link.t2c_valid = (state_reg == TS_HDR) || (state_reg == TS_DATA);
  assign link.t2c_data  = (state_reg == TS_DATA) ? data_reg[k*8 +: 8] :
                          hdr_byte;
  assign link.c2t_ready = (state_reg == TS_RESP);
  assign done_out       = done_reg;
  assign refused_out    = refused_reg;
  assign sw_out         = sw_reg;
  assign rsp_data_out   = rsp_reg;
  assign rsp_count_out  = rcnt_reg;

  // ==========================================================
  // next state
  always_comb begin
    state_next   = state_reg;
    hdr_cnt_next = hdr_cnt_reg;
    ins_next     = ins_reg;
    p1_next      = p1_reg;
    p2_next      = p2_reg;
    lc_next      = lc_reg;
    cnt_next     = cnt_reg;
    data_next    = data_reg;
    done_next    = 1'b0;
    refused_next = 1'b0;
    sw_next      = sw_reg;
    rsp_next     = rsp_reg;
    rcnt_next    = rcnt_reg;
    case (state_reg)
      TS_IDLE: begin
        if (req_valid_in) begin
          if (legal(ins_in, p1_in, p2_in, lc_in)) begin
            ins_next     = ins_in;
            p1_next      = p1_in;
            p2_next      = p2_in;
            lc_next      = lc_in;
            data_next    = data_in;
            hdr_cnt_next = HDR_CLA;
            cnt_next     = '0;
            rcnt_next    = '0;
            rsp_next     = '0;
            state_next   = TS_HDR;
          end else begin
            refused_next = 1'b1;
          end
        end
      end
      TS_HDR: begin
        if (link.t2c_ready) begin
          hdr_cnt_next = hdr_cnt_reg + 3'h1;
          if (hdr_cnt_reg == HDR_LC)
            state_next = (lc_reg == LC_EMPTY) ? TS_RESP : TS_DATA;
        end
      end
      TS_DATA: begin
        if (link.t2c_ready) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_next == lc_reg) state_next = TS_RESP;
        end
      end
      TS_RESP: begin
        if (link.c2t_valid) begin
          rsp_next  = {rsp_reg[RB-9:0], link.c2t_data};
          sw_next   = {sw_reg[7:0], link.c2t_data};
          rcnt_next = rcnt_reg + 8'h01;
          if (link.c2t_last) begin
            done_next  = 1'b1;
            state_next = TS_IDLE;
          end
        end
      end
      default: state_next = TS_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg   <= TS_IDLE;
      hdr_cnt_reg <= HDR_CLA;
      ins_reg     <= '0;
      p1_reg      <= '0;
      p2_reg      <= '0;
      lc_reg      <= '0;
      cnt_reg     <= '0;
      data_reg    <= '0;
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      sw_reg      <= '0;
      rsp_reg     <= '0;
      rcnt_reg    <= '0;
    end else begin
      state_reg   <= state_next;
      hdr_cnt_reg <= hdr_cnt_next;
      ins_reg     <= ins_next;
      p1_reg      <= p1_next;
      p2_reg      <= p2_next;
      lc_reg      <= lc_next;
      cnt_reg     <= cnt_next;
      data_reg    <= data_next;
      done_reg    <= done_next;
      refused_reg <= refused_next;
      sw_reg      <= sw_next;
      rsp_reg     <= rsp_next;
      rcnt_reg    <= rcnt_next;
    end
  end
endmodule
`default_nettype wire

// ===== bench/cip_link_chk.sv
// assertion checker for the card command link
`timescale 1ns/1ps
`default_nettype none
module cip_link_chk #(
  parameter int RECLEN = 4
) (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       t2c_valid,
  input wire logic       t2c_ready,
  input wire logic [7:0] t2c_data,
  input wire logic       c2t_valid,
  input wire logic       c2t_ready,
  input wire logic [7:0] c2t_data,
  input wire logic       c2t_last
);
  import cip_pkg::*;
  logic [7:0] nin_reg, nout_reg, ins_reg, lc_reg, sw1_reg;
  wire tin = t2c_valid && t2c_ready;
  wire tout = c2t_valid && c2t_ready;
  wire fin = tout && c2t_last;
  // ==========
  // frame tracking
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || fin) begin
      nin_reg <= 8'h00;
      nout_reg <= 8'h00;
    end else begin
      if (tin) nin_reg <= nin_reg + 8'h01;
      if (tout) nout_reg <= nout_reg + 8'h01;
    end
    if (tin && nin_reg == 8'h01) ins_reg <= t2c_data;
    if (tin && nin_reg == 8'h04) lc_reg <= t2c_data;
    if (tout) sw1_reg <= c2t_data;
  end
  // ==========
  // properties
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence exec_gap; !c2t_valid ##1 c2t_valid; endsequence
  sequence back_hdr; t2c_ready && !c2t_valid; endsequence
  cla_first_a: assert property (
    tin && nin_reg == 8'h00 |-> t2c_data == CLA_VALUE) else $error("cla");
  half_duplex_a: assert property (
    !(t2c_ready && c2t_valid)) else $error("duplex");
  answer_gap_a: assert property (
    $fell(t2c_ready) |-> exec_gap) else $error("gap");
  frame_back_a: assert property (
    fin |=> back_hdr) else $error("back");
  inc_len_a: assert property (
    fin && ins_reg == INS_INCREASE && sw1_reg == 8'h90
    |-> nout_reg == 8'(RECLEN) + lc_reg + 8'h01) else $error("len");
  retry_data_a: assert property (
    fin && sw1_reg == 8'h63 && lc_reg != LC_EMPTY
    |-> c2t_data inside {[8'hC0:8'hC2]}) else $error("retry");
  retry_query_a: assert property (
    fin && sw1_reg == 8'h63 && lc_reg == LC_EMPTY
    |-> c2t_data inside {[8'hC0:8'hC3]}) else $error("query");
  blocked_sw_a: assert property (
    fin && ins_reg == INS_VERIFY && lc_reg == LC_PIN && sw1_reg == 8'h69
    |-> c2t_data inside {8'h83, 8'h84}) else $error("blocked");
endmodule
`default_nettype wire

// ===== bench/tb.sv
// bench: terminal and card joined over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
  import cip_pkg::*;
  typedef struct {logic [7:0] n; logic [63:0] v;} cip_exp_t;
  localparam logic [63:0] PD = 64'h3132_3334_FFFF_FFFF;
  localparam logic [63:0] WR = 64'h3939_FFFF_FFFF_FFFF;
  localparam logic [63:0] NP = 64'h3535_3535_FFFF_FFFF;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, nv_init = 1'b1, req_valid = 1'b0;
  logic done, refused, req_ready, inc_cond = 1'b1, prot = 1'b0;
  logic [7:0] ins = 8'h00, p1 = 8'h00, p2 = 8'h00, lc = 8'h00;
  logic [7:0] am_tag = 8'h00, am_ins = INS_INCREASE, rsp_n;
  logic [127:0] data = '0;
  logic [15:0] sw;
  logic [319:0] rsp;
  logic [3:0] verified, blocked, dis = 4'h4;
  logic [1:0] ptr, pidx = 2'h0;
  logic [31:0] a, b;
  int error_cnt = 0, total_checks = 0, cyc = 0, seed = 44871;
  cip_exp_t q[$], e;
  cip_link_if link();
  cip_term i_cip_term (.mclk_in, .rst_n_in, .link(link),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .ins_in(ins),
    .p1_in(p1), .p2_in(p2), .lc_in(lc), .data_in(data), .done_out(done),
    .refused_out(refused), .sw_out(sw), .rsp_data_out(rsp),
    .rsp_count_out(rsp_n));
  cip_card #(.PIN_DEFAULT(PD)) i_cip_card (.mclk_in, .rst_n_in,
    .link(link), .nv_init_in(nv_init), .pin_disabled_in(dis),
    .am_tag_in(am_tag), .am_ins_in(am_ins),
    .inc_cond_met_in(inc_cond), .inc_pin_protected_in(prot),
    .inc_pin_idx_in(pidx), .pin_verified_out(verified),
    .pin_blocked_out(blocked), .rec_ptr_out(ptr));
  cip_link_chk #(.RECLEN(4)) i_cip_link_chk (.mclk_in, .rst_n_in,
    .t2c_valid(link.t2c_valid), .t2c_ready(link.t2c_ready),
    .t2c_data(link.t2c_data), .c2t_valid(link.c2t_valid),
    .c2t_ready(link.c2t_ready), .c2t_data(link.c2t_data),
    .c2t_last(link.c2t_last));
  initial forever #2.5 mclk_in = ~mclk_in;
  // ==========
  // one command, expected reply noted first
  task automatic cmd(input logic [7:0] i, p, k, l, input logic [127:0] d,
                     input logic [7:0] n, input logic [63:0] v);
    cip_exp_t x;
    x.n = n;
    x.v = v;
    q.push_back(x);
    @(negedge mclk_in);
    {ins, p1, p2, lc, data} = {i, p, k, l, d};
    req_valid = 1'b1;
    @(negedge mclk_in);
    req_valid = 1'b0;
    for (int c = 0; c < 80 && q.size() != 0; c++) @(negedge mclk_in);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge mclk_in) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      test_done();
    end else if ((done || refused) && q.size() != 0) begin
      e = q.pop_front();
      `CHK(refused ? 16'hFFFF : sw, e.v[15:0])
      `CHK(refused ? 8'h00 : rsp_n, e.n)
      `CHK(req_ready, 1'b1)
      if (e.n > 8'h02) begin
        `CHK((rsp[63:0] & {{8{e.n > 8'h07}}, {56{1'b1}}}), e.v)
      end
    end
  end
  initial begin
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1'b1;
    nv_init = 1'b0;
    cmd(INS_VERIFY, 8'h00, 8'h01, LC_EMPTY, '0, 8'h02, 16'h63C3);
    for (int t = 2; t >= 0; t--)
      cmd(INS_VERIFY, 8'h00, 8'h01, LC_PIN, WR, 8'h02,
          16'h63C0 + 16'(t));
    cmd(INS_VERIFY, 8'h00, 8'h01, LC_PIN, PD, 8'h02, SW_BLOCKED);
    cmd(INS_VERIFY, 8'h00, 8'h01, LC_EMPTY, '0, 8'h02, 16'h63C0);
    rst_n_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    rst_n_in = 1'b1;
    `CHK(blocked[0], 1'b1)
    cmd(INS_VERIFY, 8'h00, 8'h01, LC_EMPTY, '0, 8'h02, 16'h63C0);
    cmd(INS_VERIFY, 8'h00, 8'h82, LC_PIN, WR, 8'h02, 16'h63C2);
    cmd(INS_VERIFY, 8'h00, 8'h82, LC_PIN, PD, 8'h02, SW_OK);
    `CHK(verified[1], 1'b1)
    cmd(INS_VERIFY, 8'h00, 8'h02, LC_EMPTY, '0, 8'h02, 16'h63C3);
    cmd(INS_CHANGE, 8'h00, 8'h02, LC_CHANGE, {WR, NP}, 8'h02,
        16'h63C2);
    cmd(INS_CHANGE, 8'h00, 8'h02, LC_CHANGE, {PD, NP}, 8'h02,
        SW_OK);
    cmd(INS_VERIFY, 8'h00, 8'h02, LC_PIN, NP, 8'h02, SW_OK);
    cmd(INS_VERIFY, 8'h00, 8'h02, LC_PIN, PD, 8'h02, 16'h63C2);
    cmd(INS_VERIFY, 8'h00, 8'h03, LC_PIN, PD, 8'h02, SW_DISABLED);
    cmd(INS_CHANGE, 8'h00, 8'h03, LC_CHANGE, {PD, NP}, 8'h02,
        SW_DISABLED);
    cmd(INS_VERIFY, 8'h00, 8'h03, LC_EMPTY, '0, 8'h02, 16'h63C3);
    cmd(INS_VERIFY, 8'h00, 8'h05, LC_PIN, PD, 8'h02, SW_NO_REF);
    cmd(INS_VERIFY, 8'h00, 8'h00, LC_EMPTY, '0, 8'h00, 16'hFFFF);
    a = ($random(seed) & 32'hFF) | 32'h1;
    b = $random(seed) & 32'hFFFF;
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h01, 128'(a), 8'h02, SW_DENIED);
    am_tag = AM_TAG_INCREASE;
    am_ins = INS_VERIFY;
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h01, 128'(a), 8'h02, SW_DENIED);
    am_ins = INS_INCREASE;
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h01, 128'(a), 8'h07,
        {8'h00, a, a[7:0], SW_OK});
    `CHK(ptr, 2'h1)
    cmd(INS_INCREASE, 8'h81, 8'h00, 8'h02, 128'(b), 8'h08,
        {a + b, b[15:0], SW_OK});
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h04, 128'(32'hFFFF_FFFF), 8'h02,
        SW_OVERFLOW);
    `CHK(ptr, 2'h2)
    cmd(INS_INCREASE, 8'h82, 8'h00, 8'h01, 128'(a), 8'h02,
        SW_NO_FILE);
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h05, 128'(a), 8'h02,
        SW_WRONG_LEN);
    cmd(INS_INCREASE, 8'h40, 8'h00, 8'h01, 128'(a), 8'h00, 16'hFFFF);
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h00, '0, 8'h00, 16'hFFFF);
    prot = 1'b1;
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h01, 128'(1), 8'h02,
        SW_DENIED);
    pidx = 2'h2;
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h01, 128'(1), 8'h07,
        {8'h00, a + b + 32'h1, 8'h01, SW_OK});
    inc_cond = 1'b0;
    cmd(INS_INCREASE, 8'h00, 8'h00, 8'h01, 128'(1), 8'h02,
        SW_DENIED);
    dis = 4'h0;
    cmd(INS_VERIFY, 8'h00, 8'h03, LC_PIN, PD, 8'h02, SW_OK);
    test_done();
  end
endmodule
`default_nettype wire
